// ==== hdl/agp_regs_pkg.sv ====
// Package: offsets, fields, reset values and carriers for the AGP register pair
package agp_regs_pkg;
    localparam logic [7:0]  STATUS_OFS     = 8'hA4;
    localparam logic [7:0]  COMMAND_OFS    = 8'hA8;
    localparam logic [31:0] STATUS_RESET   = 32'h1F000217;
    localparam logic [31:0] COMMAND_RESET  = 32'h00000000;
    localparam logic [31:0] COMMAND_WMASK  = 32'h00000317;
    localparam logic [7:0]  REQ_DEPTH_CODE   = 8'h1F;
    localparam int          REQ_DEPTH_LSB    = 24;
    localparam int          SIDEBAND_SUP_BIT = 9;
    localparam int          GT4G_BIT         = 5;
    localparam int          FASTWR_SUP_BIT   = 4;
    localparam int          IF_EN_BIT        = 8;
    localparam int          SIDEBAND_EN_BIT  = 9;
    localparam int          FASTWR_EN_BIT    = 4;
    localparam logic [2:0]  RATE_CAP_ALL     = 3'h7;
    localparam logic [2:0]  RATE_1X        = 3'h1;
    localparam logic [2:0]  RATE_2X        = 3'h2;
    localparam logic [2:0]  RATE_4X        = 3'h4;

    typedef struct packed {
        logic       sidebandAddrEnable;
        logic       interfaceEnable;
        logic       fastWriteEnable;
        logic [2:0] rateSelect;
    } cmd_t;

    typedef enum logic [1:0] {
        SB_IDLE = 2'h0,
        SB_PART = 2'h1
    } sb_state_t;
endpackage

// ==== hdl/agp_status_command_regs.sv ====
// AGP capability status and operation command registers with operation gating
// Contract
// - Queue depth field reads 1Fh, 32 requests
// - Sideband support bit always reads one
// - Above-4GB support bit always reads zero
// - Fast write support bit always reads one
// - Rate capability reports 1X, 2X, 4X
// - Status register read-only, writes ignored
// - Command register resets to all zeros
// - Interface disabled ignores all operations, sync too; code still drives useFastWrite for memory writes
// - Accepted operations complete after disable
// - Partial 1X sideband command still issued
// - Pipe accepted when enabled; sideband needs enable
// - Fast-write off or 1X uses PCI protocol
// - Fast writes use selected rate
`timescale 1ns/1ps
`default_nettype none
module agp_status_command_regs (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic      [31:0] regRdData,
    input  wire logic        pipeOpValid,
    input  wire logic        syncOpValid,
    input  wire logic        sbCmdStart,
    input  wire logic        sbCmdDone,
    input  wire logic        memWriteReq,
    output logic             pipeOpAccept,
    output logic             syncOpAccept,
    output logic             sbCmdIssue,
    output logic             useFastWrite,
    output logic      [2:0]  activeRate,
    output logic             interfaceEnable,
    output logic             sidebandAddrEnable
);
    function automatic logic oneHot3(input logic [2:0] v);
        return (v == agp_regs_pkg::RATE_1X) || (v == agp_regs_pkg::RATE_2X)
            || (v == agp_regs_pkg::RATE_4X);
    endfunction

    logic [31:0]             statusWord;
    agp_regs_pkg::cmd_t      cmd_ff, nxt_cmd;
    logic [31:0]             cmdWord;
    logic [31:0]             rdData_ff, nxt_rdData;
    agp_regs_pkg::sb_state_t sb_ff, nxt_sb;
    logic                    rateValid;

    // Status is pure wiring, so no write path exists to disturb it
    always_comb begin
        statusWord = '0;
        statusWord[31:agp_regs_pkg::REQ_DEPTH_LSB] = agp_regs_pkg::REQ_DEPTH_CODE;
        statusWord[agp_regs_pkg::SIDEBAND_SUP_BIT] = 1'b1;
        statusWord[agp_regs_pkg::GT4G_BIT] = 1'b0;
        statusWord[agp_regs_pkg::FASTWR_SUP_BIT] = 1'b1;
        statusWord[2:0] = agp_regs_pkg::RATE_1X | agp_regs_pkg::RATE_2X
            | agp_regs_pkg::RATE_4X;
    end

    always_comb begin
        cmdWord = '0;
        cmdWord[agp_regs_pkg::SIDEBAND_EN_BIT] = cmd_ff.sidebandAddrEnable;
        cmdWord[agp_regs_pkg::IF_EN_BIT] = cmd_ff.interfaceEnable;
        cmdWord[agp_regs_pkg::FASTWR_EN_BIT] = cmd_ff.fastWriteEnable;
        cmdWord[2:0] = cmd_ff.rateSelect;
    end

    always_comb begin
        nxt_cmd = cmd_ff;
        nxt_rdData = '0;
        if (regWrStb && regAddr == agp_regs_pkg::COMMAND_OFS) begin
            nxt_cmd.sidebandAddrEnable = regWrData[agp_regs_pkg::SIDEBAND_EN_BIT];
            nxt_cmd.interfaceEnable = regWrData[agp_regs_pkg::IF_EN_BIT];
            nxt_cmd.fastWriteEnable = regWrData[agp_regs_pkg::FASTWR_EN_BIT];
            nxt_cmd.rateSelect = regWrData[2:0];
        end
        if (regRdStb) begin
            unique case (regAddr)
                agp_regs_pkg::STATUS_OFS:  nxt_rdData = statusWord;
                agp_regs_pkg::COMMAND_OFS: nxt_rdData = cmdWord & agp_regs_pkg::COMMAND_WMASK;
                default:                   nxt_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_ff <= '0;
            rdData_ff <= '0;
        end else begin
            cmd_ff <= nxt_cmd;
            rdData_ff <= nxt_rdData;
        end
    end

    assign regRdData = rdData_ff;
    assign interfaceEnable = cmd_ff.interfaceEnable;
    assign sidebandAddrEnable = cmd_ff.sidebandAddrEnable;
    assign rateValid = oneHot3(cmd_ff.rateSelect);
    assign activeRate = rateValid ? cmd_ff.rateSelect : 3'h0;

    // Admission only at the start; work already admitted finishes elsewhere
    assign pipeOpAccept = cmd_ff.interfaceEnable && pipeOpValid;
    assign syncOpAccept = cmd_ff.interfaceEnable && syncOpValid;

    // Sideband tracker: a command begun while enabled is carried to issue
    always_comb begin
        nxt_sb = sb_ff;
        sbCmdIssue = 1'b0;
        unique case (sb_ff)
            agp_regs_pkg::SB_IDLE: begin
                if (sbCmdStart && cmd_ff.interfaceEnable && cmd_ff.sidebandAddrEnable) begin
                    nxt_sb = agp_regs_pkg::SB_PART;
                end
            end
            agp_regs_pkg::SB_PART: begin
                if (sbCmdDone) begin
                    // Issued whatever the enable or rate now is, which covers the 1X case
                    sbCmdIssue = 1'b1;
                    nxt_sb = agp_regs_pkg::SB_IDLE;
                end
            end
            default: nxt_sb = agp_regs_pkg::SB_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sb_ff <= agp_regs_pkg::SB_IDLE;
        end else begin
            sb_ff <= nxt_sb;
        end
    end

    // Fast write needs enable and a valid rate above 1X
    assign useFastWrite = memWriteReq && cmd_ff.fastWriteEnable && rateValid
        && (cmd_ff.rateSelect != agp_regs_pkg::RATE_1X);

    status_const_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regRdStb && regAddr == agp_regs_pkg::STATUS_OFS
        |=> regRdData == agp_regs_pkg::STATUS_RESET)
        else $error("status word wrong");
    rq_field_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regRdStb && regAddr == agp_regs_pkg::STATUS_OFS
        |=> regRdData[31:agp_regs_pkg::REQ_DEPTH_LSB] == agp_regs_pkg::REQ_DEPTH_CODE)
        else $error("queue depth wrong");
    sba_sup_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regRdStb && regAddr == agp_regs_pkg::STATUS_OFS
        |=> regRdData[agp_regs_pkg::SIDEBAND_SUP_BIT])
        else $error("sideband support bit wrong");
    gt4g_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regRdStb && regAddr == agp_regs_pkg::STATUS_OFS
        |=> !regRdData[agp_regs_pkg::GT4G_BIT])
        else $error("above 4GB bit set");
    fw_sup_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regRdStb && regAddr == agp_regs_pkg::STATUS_OFS
        |=> regRdData[agp_regs_pkg::FASTWR_SUP_BIT])
        else $error("fast write support bit wrong");
    rate_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regRdStb && regAddr == agp_regs_pkg::STATUS_OFS
        |=> regRdData[2:0] == agp_regs_pkg::RATE_CAP_ALL)
        else $error("rate capability wrong");
    cmd_reset_a: assert property (@(posedge ref_clk) $rose(rst_b) |-> cmdWord == agp_regs_pkg::COMMAND_RESET)
        else $error("command not cleared by reset");
    disabled_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !interfaceEnable |-> !pipeOpAccept && !syncOpAccept)
        else $error("operation accepted while disabled");
    sb_finish_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sb_ff == agp_regs_pkg::SB_PART && sbCmdDone |-> sbCmdIssue)
        else $error("begun sideband command dropped");
    sb_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sb_ff == agp_regs_pkg::SB_IDLE && sbCmdStart && !sidebandAddrEnable
        |=> sb_ff == agp_regs_pkg::SB_IDLE)
        else $error("sideband taken without enable");
    sb_disabled_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sb_ff == agp_regs_pkg::SB_IDLE && sbCmdStart && !interfaceEnable
        |=> sb_ff == agp_regs_pkg::SB_IDLE)
        else $error("sideband taken while disabled");
    sb_idle_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sb_ff == agp_regs_pkg::SB_IDLE |-> !sbCmdIssue)
        else $error("sideband issue without a begun command");
    pci_path_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!cmd_ff.fastWriteEnable || activeRate == agp_regs_pkg::RATE_1X) |-> !useFastWrite)
        else $error("fast write used when not allowed");
    fast_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        useFastWrite |-> activeRate == agp_regs_pkg::RATE_2X || activeRate == agp_regs_pkg::RATE_4X)
        else $error("fast write without a usable rate");
    rate_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !oneHot3(cmd_ff.rateSelect) |-> activeRate == 3'h0 && !useFastWrite)
        else $error("invalid rate treated as valid");
    cmd_rsvd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regRdStb && regAddr == agp_regs_pkg::COMMAND_OFS
        |=> (regRdData & ~agp_regs_pkg::COMMAND_WMASK) == 32'h00000000)
        else $error("reserved command bits nonzero");
endmodule // agp_status_command_regs
`default_nettype wire

// ==== tb/agp_master_model.sv ====
// AGP master model: operation requests and sideband command phases
`timescale 1ns/1ps
`default_nettype none
module agp_master_model (
    input  wire logic ref_clk,
    input  wire logic sbCmdIssue,
    output logic      pipeOpValid,
    output logic      syncOpValid,
    output logic      sbCmdStart,
    output logic      sbCmdDone,
    output logic      memWriteReq
);
    initial {pipeOpValid, syncOpValid, sbCmdStart, sbCmdDone, memWriteReq} = 5'h00;
    task automatic ops(input logic [2:0] v);
        @(posedge ref_clk) {pipeOpValid, syncOpValid, memWriteReq} <= v;
    endtask
    // Start and last part apart, so software may act in the middle
    task automatic sbStart();
        @(posedge ref_clk) sbCmdStart <= 1'b1;
        @(posedge ref_clk) sbCmdStart <= 1'b0;
    endtask
    task automatic sbFinish(output logic iss);
        @(posedge ref_clk) sbCmdDone <= 1'b1;
        #1 iss = sbCmdIssue;
        @(posedge ref_clk) sbCmdDone <= 1'b0;
    endtask
endmodule // agp_master_model
`default_nettype wire

// ==== tb/agp_status_command_regs_tb.sv ====
// Self-checking bench for the AGP status and command register pair
`timescale 1ns/1ps
`default_nettype none
module agp_status_command_regs_tb;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h00000000;
    logic        regWrStb = 1'b0;
    logic        regRdStb = 1'b0;
    logic [31:0] regRdData;
    logic        pipeOpValid, syncOpValid, sbCmdStart, sbCmdDone, memWriteReq;
    logic        pipeOpAccept, syncOpAccept, sbCmdIssue, useFastWrite, iss;
    logic [2:0]  activeRate, r;
    logic        interfaceEnable, sidebandAddrEnable;
    logic [31:0] fwTab [6] = '{32'h010, 32'h011, 32'h012, 32'h014, 32'h013, 32'h004};
    int          failures = 0;
    int          checks = 0;
    always #2 ref_clk = ~ref_clk;
    agp_status_command_regs u_agp_status_command_regs (.ref_clk(ref_clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .pipeOpValid(pipeOpValid), .syncOpValid(syncOpValid),
        .sbCmdStart(sbCmdStart), .sbCmdDone(sbCmdDone), .memWriteReq(memWriteReq),
        .pipeOpAccept(pipeOpAccept), .syncOpAccept(syncOpAccept), .sbCmdIssue(sbCmdIssue),
        .useFastWrite(useFastWrite), .activeRate(activeRate),
        .interfaceEnable(interfaceEnable), .sidebandAddrEnable(sidebandAddrEnable));
    agp_master_model u_agp_master_model (.ref_clk(ref_clk), .sbCmdIssue(sbCmdIssue),
        .pipeOpValid(pipeOpValid), .syncOpValid(syncOpValid), .sbCmdStart(sbCmdStart),
        .sbCmdDone(sbCmdDone), .memWriteReq(memWriteReq));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) begin
            regWrStb <= 1'b1;
            regAddr <= a;
            regWrData <= d;
        end
        @(posedge ref_clk) regWrStb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge ref_clk) begin
            regRdStb <= 1'b1;
            regAddr <= a;
        end
        @(posedge ref_clk) regRdStb <= 1'b0;
        #1 chk(what, exp, regRdData);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdchk(agp_regs_pkg::STATUS_OFS, 32'h1F000217, "status");
        rdchk(agp_regs_pkg::COMMAND_OFS, 32'h00000000, "command");
        wr(agp_regs_pkg::STATUS_OFS, 32'hFFFFFFFF);
        rdchk(agp_regs_pkg::STATUS_OFS, 32'h1F000217, "status");
        rdchk(8'hAC, 32'h00000000, "unmapped");
        u_agp_master_model.ops(3'h6);
        #1 chk("pipe", 0, pipeOpAccept);
        chk("sync", 0, syncOpAccept);
        u_agp_master_model.sbStart();
        u_agp_master_model.sbFinish(iss);
        chk("issue", 0, iss);
        wr(agp_regs_pkg::COMMAND_OFS, 32'hFFFFFFFF);
        rdchk(agp_regs_pkg::COMMAND_OFS, 32'h00000317, "command");
        wr(agp_regs_pkg::COMMAND_OFS, 32'h00000100);
        #1 chk("pipe", 1, pipeOpAccept);
        chk("ifen", 1, interfaceEnable);
        chk("sben", 0, sidebandAddrEnable);
        chk("sync", 1, syncOpAccept);
        u_agp_master_model.sbStart();
        u_agp_master_model.sbFinish(iss);
        chk("issue", 0, iss);
        wr(agp_regs_pkg::COMMAND_OFS, 32'h00000311);
        #1 chk("sben", 1, sidebandAddrEnable);
        chk("rate", 32'h1, activeRate);
        u_agp_master_model.sbStart();
        wr(agp_regs_pkg::COMMAND_OFS, 32'h00000000);
        u_agp_master_model.sbFinish(iss);
        chk("issue", 1, iss);
        chk("pipe", 0, pipeOpAccept);
        chk("ifen", 0, interfaceEnable);
        u_agp_master_model.ops(3'h1);
        foreach (fwTab[i]) begin
            r = fwTab[i][2:0];
            wr(agp_regs_pkg::COMMAND_OFS, fwTab[i]);
            #1 chk("rate", (r inside {3'h1, 3'h2, 3'h4}) ? r : 3'h0, activeRate);
            chk("fast", fwTab[i][4] && r inside {3'h2, 3'h4}, useFastWrite);
        end
        stop_test();
    end
    // A hang ends the run as a mismatch
    initial begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        stop_test();
    end
endmodule // agp_status_command_regs_tb
`default_nettype wire
